// [src/tbc_pkg.sv]
// package of constants for the time base counter block
package tbc_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] TBC_IDX_READOUT   = 16'hF00A;
  localparam logic [15:0] TBC_IDX_RATIO     = 16'hF00B;
  localparam logic [15:0] TBC_IDX_TRIM_LO   = 16'hF00C;
  localparam logic [15:0] TBC_IDX_TRIM_HI   = 16'hF00D;
  localparam logic [15:0] TBC_IDX_IRQ_STAT  = 16'hF00E;
  localparam logic [15:0] TBC_IDX_IRQ_MASK  = 16'hF00F;

  localparam int          TBC_ADDR_W        = 18;

  // reset values
  localparam logic [3:0]  TBC_RATIO_RST     = 4'h0;
  localparam logic [7:0]  TBC_TRIM_LO_RST   = 8'h00;
  localparam logic [2:0]  TBC_TRIM_HI_RST   = 3'h0;
  localparam logic [3:0]  TBC_IRQ_RST       = 4'h0;
  localparam logic [14:0] TBC_CHAIN_RST     = 15'h0000;

  // chain layout: bit i of the chain counter is the tap at 16 kHz >> i
  localparam int          TBC_CHAIN_W       = 15;
  localparam int          TBC_TAP_128_POS   = 7;
  localparam int          TBC_TAP_32_POS    = 9;
  localparam int          TBC_TAP_16_POS    = 10;
  localparam int          TBC_TAP_2_POS     = 13;
  localparam int          TBC_TAP_1_POS     = 14;

  // interrupt status and mask bit positions
  localparam int          TBC_IRQ_128_BIT   = 0;
  localparam int          TBC_IRQ_32_BIT    = 1;
  localparam int          TBC_IRQ_16_BIT    = 2;
  localparam int          TBC_IRQ_2_BIT     = 3;

  // trim field layout
  localparam int          TBC_TRIM_W        = 11;
  localparam int          TBC_TRIM_SIGN_POS = 10;
  localparam int          TBC_ACC_W         = 21;

  // fast side prescaler width, taps 1/1 .. 1/32
  localparam int          TBC_FAST_PRE_W    = 5;

  // byte address of a register index
  function automatic logic [TBC_ADDR_W-1:0] tbc_byte_addr(input logic [15:0] idx);
    tbc_byte_addr = {idx, 2'b00};
  endfunction : tbc_byte_addr

endpackage : tbc_pkg

// [src/tbc_time_base_counter.sv]
// time base counter: slow divider chain with trim and interrupts, fast 1/n divider, apb registers
// Functional notes
// - the slow input clock is divided by a binary chain giving taps from about 32 kHz to 1 Hz.
// - the fast input clock is divided into a set of fast base taps for peripherals.
// - falling edges of the 128 Hz, 32 Hz, 16 Hz and 2 Hz taps each raise their own interrupt request.
// - after reset the slow chain starts from zero and advances on slow clock falling edges.
// - reading the tap readout register returns the taps from 128 Hz down to 1 Hz.
// - any write to the tap readout register clears the 128 Hz to 1 Hz taps and the data is ignored.
// - a falling edge caused by that clear still raises the tap's interrupt request.
// - the low four bits of the ratio register select division by 16 minus the field, reset 1/16.
// - the divided fast clock feeds the timers and the pwm unit.
// - the slow chain taps are also handed to other peripherals as clocks.
// - the trim is an 11-bit two's complement value in steps of about 0.48 ppm.
// - the trim equals the wanted fractional correction times 2097152, one step per 2^21 counts.
// - the trim acts only on taps from 8 kHz down, never on the input clock or the 32k and 16k taps.
// - trim sign and top two magnitude bits sit in bits 2-0 of the high byte, the rest in the low byte.
// - the block makes the gate reference for the cascaded 16-bit timer frequency measurement.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module tbc_time_base_counter
  import tbc_pkg::*;
#(
  parameter int FAST_PRE_W = TBC_FAST_PRE_W
)(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   slow_input_clock,
  input  wire logic                   fast_input_clock,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [TBC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  output logic      [TBC_CHAIN_W:0]   slow_taps,
  output logic      [FAST_PRE_W:0]    fast_taps,
  output logic                        fast_divided_clock,
  output logic                        freq_measure_gate
);

  // reset release through two flip-flops
  logic                   rst_s1_r;
  logic                   rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1_r   <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  // pin synchronisers, three stages; first stage feeds only the second
  logic [2:0]             slow_sync_r;
  logic [2:0]             fast_sync_r;
  logic                   slow_lvl_r;
  logic                   fast_lvl_r;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      slow_sync_r <= 3'h0;
      fast_sync_r <= 3'h0;
      slow_lvl_r  <= 1'b0;
      fast_lvl_r  <= 1'b0;
    end
    else
    begin
      slow_sync_r <= {slow_sync_r[1:0], slow_input_clock};
      fast_sync_r <= {fast_sync_r[1:0], fast_input_clock};
      if (slow_sync_r[1] == slow_sync_r[2])
        slow_lvl_r <= slow_sync_r[2];
      if (fast_sync_r[1] == fast_sync_r[2])
        fast_lvl_r <= fast_sync_r[2];
    end
  end

  // a change counts once stages two and three agree on the new level
  function automatic logic tbc_edge(input logic lvl, input logic s2, input logic s3, input logic rise);
    tbc_edge = rise ? (!lvl && s2 && s3) : (lvl && !s2 && !s3);
  endfunction : tbc_edge

  wire slow_fall = tbc_edge(slow_lvl_r, slow_sync_r[1], slow_sync_r[2], 1'b0);
  wire fast_rise = tbc_edge(fast_lvl_r, fast_sync_r[1], fast_sync_r[2], 1'b1);

  // apb decode; zero wait states
  wire        sel_read   = (paddr == tbc_byte_addr(TBC_IDX_READOUT));
  wire        sel_ratio  = (paddr == tbc_byte_addr(TBC_IDX_RATIO));
  wire        sel_trl    = (paddr == tbc_byte_addr(TBC_IDX_TRIM_LO));
  wire        sel_trh    = (paddr == tbc_byte_addr(TBC_IDX_TRIM_HI));
  wire        sel_stat   = (paddr == tbc_byte_addr(TBC_IDX_IRQ_STAT));
  wire        sel_mask   = (paddr == tbc_byte_addr(TBC_IDX_IRQ_MASK));
  wire        mapped     = sel_read | sel_ratio | sel_trl | sel_trh | sel_stat | sel_mask;
  wire        acc_phase  = psel && penable;
  wire        wr_en      = acc_phase && pwrite && mapped;
  wire        setup      = psel && !penable;

  assign pready  = 1'b1;
  assign pslverr = acc_phase && !mapped;

  // registers
  logic [3:0]             ratio_r;
  logic [7:0]             trim_lo_r;
  logic [2:0]             trim_hi_r;
  logic [3:0]             irq_stat_r;
  logic [3:0]             irq_stat_nxt;
  logic [3:0]             irq_mask_r;
  logic [TBC_CHAIN_W-1:0] chain_r;
  logic [TBC_CHAIN_W-1:0] chain_nxt;
  logic [TBC_CHAIN_W-1:0] chain_prev_r;
  logic [TBC_ACC_W-1:0]   acc_r;
  logic [31:0]            prdata_r;

  // trim value assembled from both bytes
  wire [TBC_TRIM_W-1:0] trim_val  = {trim_hi_r, trim_lo_r};
  wire                  trim_neg  = trim_val[TBC_TRIM_SIGN_POS];
  wire [TBC_TRIM_W-1:0] trim_mag  = trim_neg ? (~trim_val + 11'h001) : trim_val;

  // the 16k stage runs untrimmed; its carry clocks the trimmed upper chain
  wire                  carry     = slow_fall && chain_r[0];
  wire [TBC_ACC_W:0]    acc_sum   = {1'b0, acc_r} + {11'h000, trim_mag};
  wire                  acc_ovf   = carry && acc_sum[TBC_ACC_W];
  wire                  do_insert = acc_ovf && !trim_neg;
  wire                  do_skip   = acc_ovf && trim_neg;
  wire [1:0]            step      = !carry ? 2'h0 : do_insert ? 2'h2 : do_skip ? 2'h0 : 2'h1;
  wire [TBC_CHAIN_W-2:0] upper    = chain_r[TBC_CHAIN_W-1:1] + {12'h000, step};
  wire                  clr_taps  = wr_en && sel_read;

  always_comb
  begin
    chain_nxt = {upper, chain_r[0] ^ slow_fall};
    if (clr_taps)
      chain_nxt[TBC_TAP_1_POS:TBC_TAP_128_POS] = 8'h00;
  end

  // falling edges of interrupt taps, including those forced by the clear
  wire [3:0] tap_fall = {chain_prev_r[TBC_TAP_2_POS]   && !chain_r[TBC_TAP_2_POS],
                         chain_prev_r[TBC_TAP_16_POS]  && !chain_r[TBC_TAP_16_POS],
                         chain_prev_r[TBC_TAP_32_POS]  && !chain_r[TBC_TAP_32_POS],
                         chain_prev_r[TBC_TAP_128_POS] && !chain_r[TBC_TAP_128_POS]};

  // set wins over the write-one clear
  wire [3:0] stat_clr = (wr_en && sel_stat) ? pwdata[3:0] : 4'h0;
  assign irq_stat_nxt = (irq_stat_r & ~stat_clr) | tap_fall;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      chain_r      <= TBC_CHAIN_RST;
      chain_prev_r <= TBC_CHAIN_RST;
      acc_r        <= '0;
      irq_stat_r   <= TBC_IRQ_RST;
    end
    else
    begin
      chain_r      <= chain_nxt;
      chain_prev_r <= chain_r;
      if (carry)
        acc_r <= acc_sum[TBC_ACC_W-1:0];
      irq_stat_r   <= irq_stat_nxt;
    end
  end

  // software registers; only the documented field bits are stored
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ratio_r    <= TBC_RATIO_RST;
      trim_lo_r  <= TBC_TRIM_LO_RST;
      trim_hi_r  <= TBC_TRIM_HI_RST;
      irq_mask_r <= TBC_IRQ_RST;
    end
    else if (wr_en)
    begin
      if (sel_ratio)
        ratio_r <= pwdata[3:0];
      if (sel_trl)
        trim_lo_r <= pwdata[7:0];
      if (sel_trh)
        trim_hi_r <= pwdata[2:0];
      if (sel_mask)
        irq_mask_r <= pwdata[3:0];
    end
  end

  // read data is latched in the setup cycle so the access phase sees a stable word
  wire [31:0] rd_mux = sel_read  ? {24'h0, chain_r[TBC_TAP_1_POS:TBC_TAP_128_POS]} :
                       sel_ratio ? {28'h0, ratio_r}    :
                       sel_trl   ? {24'h0, trim_lo_r}  :
                       sel_trh   ? {29'h0, trim_hi_r}  :
                       sel_stat  ? {28'h0, irq_stat_r} :
                       sel_mask  ? {28'h0, irq_mask_r} : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      prdata_r <= 32'h0;
    else if (setup && !pwrite)
      prdata_r <= rd_mux;
  end

  assign prdata = prdata_r;

  // fast 1/n divider: terminal count is 15 minus field, i.e. its inverse
  logic [3:0]             fdiv_cnt_r;
  logic                   fdiv_out_r;
  logic [FAST_PRE_W-1:0]  fpre_r;
  wire  [3:0]             fdiv_term = ~ratio_r;
  wire                    fdiv_wrap = fast_rise && (fdiv_cnt_r >= fdiv_term);

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fdiv_cnt_r <= 4'h0;
      fdiv_out_r <= 1'b0;
      fpre_r     <= '0;
    end
    else
    begin
      if (fdiv_wrap)
        fdiv_cnt_r <= 4'h0;
      else if (fast_rise)
        fdiv_cnt_r <= fdiv_cnt_r + 4'h1;
      fdiv_out_r <= fdiv_wrap;
      if (fast_rise)
        fpre_r <= fpre_r + {{(FAST_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // outputs; timers and pwm take the one-cycle strobe as their count enable
  assign fast_divided_clock = fdiv_out_r;
  assign fast_taps          = {fpre_r, fast_lvl_r};
  assign slow_taps          = {chain_r, slow_lvl_r};
  assign freq_measure_gate  = chain_r[TBC_TAP_1_POS];
  assign irq                = |(irq_stat_r & irq_mask_r);

  // checks
  property p_readout;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (setup && !pwrite && sel_read) |=> (prdata[7:0] == $past(chain_r[TBC_TAP_1_POS:TBC_TAP_128_POS]));
  endproperty
  a_readout: assert property (p_readout) else $error("readout mismatch");

  property p_clear;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    clr_taps |=> (chain_r[TBC_TAP_1_POS:TBC_TAP_128_POS] == 8'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("taps not cleared");

  property p_irq128;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    $fell(chain_r[TBC_TAP_128_POS]) |=> irq_stat_r[TBC_IRQ_128_BIT];
  endproperty
  a_irq128: assert property (p_irq128) else $error("128 Hz request lost");

  property p_clear_irq;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (clr_taps && chain_r[TBC_TAP_2_POS]) |=> ##1 irq_stat_r[TBC_IRQ_2_BIT];
  endproperty
  a_clear_irq: assert property (p_clear_irq) else $error("clear edge gave no request");

  property p_fast_wrap;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (fast_rise && fdiv_cnt_r == ~ratio_r) |=> (fdiv_cnt_r == 4'h0 && fast_divided_clock);
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("divider wrap wrong");

  property p_ratio_reset;
    @(posedge sys_clk) $rose(rst_sync_n) |-> (ratio_r == 4'h0 && chain_r == 15'h0000);
  endproperty
  a_ratio_reset: assert property (p_ratio_reset) else $error("reset state wrong");

  property p_16k;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    slow_fall |=> (chain_r[0] != $past(chain_r[0]));
  endproperty
  a_16k: assert property (p_16k) else $error("16k stage not untrimmed");

  property p_notrim;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (carry && trim_val == 11'h000 && !clr_taps)
      |=> (chain_r[TBC_CHAIN_W-1:1] == $past(chain_r[TBC_CHAIN_W-1:1]) + 14'h0001);
  endproperty
  a_notrim: assert property (p_notrim) else $error("chain step wrong");

  property p_skip;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (do_skip && !clr_taps) |=> (chain_r[TBC_CHAIN_W-1:1] == $past(chain_r[TBC_CHAIN_W-1:1]));
  endproperty
  a_skip: assert property (p_skip) else $error("negative trim did not skip");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (acc_phase && !mapped) |-> (pslverr && pready);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  property p_irq32;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    $fell(chain_r[TBC_TAP_32_POS]) |=> irq_stat_r[TBC_IRQ_32_BIT];
  endproperty
  a_irq32: assert property (p_irq32) else $error("32 Hz request lost");

  property p_irq16;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    $fell(chain_r[TBC_TAP_16_POS]) |=> irq_stat_r[TBC_IRQ_16_BIT];
  endproperty
  a_irq16: assert property (p_irq16) else $error("16 Hz request lost");

  property p_irq2;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    $fell(chain_r[TBC_TAP_2_POS]) |=> irq_stat_r[TBC_IRQ_2_BIT];
  endproperty
  a_irq2: assert property (p_irq2) else $error("2 Hz request lost");

  property p_strobe_src;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    fast_divided_clock |-> $past(fast_rise);
  endproperty
  a_strobe_src: assert property (p_strobe_src) else $error("divided strobe without fast edge");

  property p_16k_hold;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    !slow_fall |=> (chain_r[0] == $past(chain_r[0]));
  endproperty
  a_16k_hold: assert property (p_16k_hold) else $error("16k stage moved without slow edge");

  property p_insert;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (do_insert && !clr_taps) |=> (chain_r[TBC_CHAIN_W-1:1] == $past(chain_r[TBC_CHAIN_W-1:1]) + 14'h0002);
  endproperty
  a_insert: assert property (p_insert) else $error("positive trim did not insert");

  property p_acc_hold;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    !carry |=> (acc_r == $past(acc_r));
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("trim accumulator moved off carry");

  property p_prescale;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    fast_rise |=> (fpre_r == FAST_PRE_W'($past(fpre_r) + 1'b1));
  endproperty
  a_prescale: assert property (p_prescale) else $error("fast prescaler missed an edge");

  property p_trim_hi;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (wr_en && sel_trh) |=> (trim_val[TBC_TRIM_W-1:8] == $past(pwdata[2:0]));
  endproperty
  a_trim_hi: assert property (p_trim_hi) else $error("trim high bits misplaced");

  property p_ratio_wr;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (wr_en && sel_ratio) |=> (ratio_r == $past(pwdata[3:0]));
  endproperty
  a_ratio_wr: assert property (p_ratio_wr) else $error("ratio field not stored");

  c_clear_irq: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) clr_taps ##2 irq);
  c_insert:    cover property (@(posedge sys_clk) disable iff (!rst_sync_n) do_insert);
  c_skip:      cover property (@(posedge sys_clk) disable iff (!rst_sync_n) do_skip);
  c_div1:      cover property (@(posedge sys_clk) disable iff (!rst_sync_n) ratio_r == 4'hF ##1 fast_divided_clock);
  c_irq2:      cover property (@(posedge sys_clk) disable iff (!rst_sync_n) $fell(chain_r[TBC_TAP_2_POS]));

endmodule : tbc_time_base_counter

// [verification/tbc_far_side_model.sv]
// far side model: clock sources feeding the block and a peripheral consuming the divided strobe
`timescale 1ns/10ps
module tbc_far_side_model (
  input  wire logic sys_clk,
  input  wire logic fast_divided_clock,
  output logic      slow_input_clock,
  output logic      fast_input_clock,
  output int        strobe_gap
);
  logic [1:0] ph_r;
  int         edges;
  int         last_edge;

  // fast source runs free; one half period is four system cycles, well below the sampler limit
  initial
  begin
    slow_input_clock = 1'b0;
    fast_input_clock = 1'b0;
    ph_r             = 2'h0;
    edges            = 0;
    last_edge        = 0;
    strobe_gap       = 0;
  end

  always @(posedge sys_clk)
  begin
    ph_r <= ph_r + 2'h1;
    if (ph_r == 2'h3)
    begin
      fast_input_clock <= ~fast_input_clock;
      if (!fast_input_clock)
        edges <= edges + 1;
    end
    // timer side counts fast edges between divided strobes
    if (fast_divided_clock === 1'b1)
    begin
      strobe_gap <= edges - last_edge;
      last_edge  <= edges;
    end
  end

  // slow source stands still between bursts so the chain state is exactly known
  task automatic run_slow(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge sys_clk);
      slow_input_clock <= 1'b1;
      repeat (3) @(posedge sys_clk);
      slow_input_clock <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
  endtask : run_slow
endmodule : tbc_far_side_model

// [verification/tb_top.sv]
// testbench for the time base counter: apb register tests, divider ratios, chain, interrupts
`timescale 1ns/10ps
module tb_top;
  import tbc_pkg::*;
  logic                  sys_clk;
  logic                  rst_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [TBC_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  irq;
  logic [TBC_CHAIN_W:0]  slow_taps;
  logic [5:0]            fast_taps;
  logic                  fast_divided_clock;
  logic                  freq_measure_gate;
  logic                  slow_input_clock;
  logic                  fast_input_clock;
  int                    strobe_gap;
  int                    n_errors;
  int                    samples_checked;
  int                    cyc;
  logic [31:0]           rq;
  logic                  re;
  logic [3:0]            ks [4] = '{4'h0, 4'hF, 4'hE, 4'h8};

  tbc_time_base_counter DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .slow_input_clock(slow_input_clock),
    .fast_input_clock(fast_input_clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .slow_taps(slow_taps), .fast_taps(fast_taps),
    .fast_divided_clock(fast_divided_clock), .freq_measure_gate(freq_measure_gate)
  );

  tbc_far_side_model u_far (
    .sys_clk(sys_clk), .fast_divided_clock(fast_divided_clock),
    .slow_input_clock(slow_input_clock), .fast_input_clock(fast_input_clock), .strobe_gap(strobe_gap)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // one transfer: setup, then access held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk_bit(pready, 1'b1);
  endtask : apb

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk_val(rq, exp);
    chk_bit(re, 1'b0);
  endtask : rd_chk

  // counting chain may move mid-access, so two reads must agree
  task automatic rd_stable(input logic [31:0] exp);
    logic [31:0] first;
    int          n;
    n = 0;
    do
    begin
      apb(1'b0, TBC_IDX_READOUT, 32'h0000_0000);
      first = rq;
      apb(1'b0, TBC_IDX_READOUT, 32'h0000_0000);
      n++;
    end
    while (first !== rq && n < 8);
    chk_val(rq, exp);
  endtask : rd_stable

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      test_done();
    end
  end

  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk(TBC_IDX_READOUT, 32'h0000_0000);
    rd_chk(TBC_IDX_RATIO, 32'h0000_0000);
    rd_chk(TBC_IDX_TRIM_LO, 32'h0000_0000);
    rd_chk(TBC_IDX_TRIM_HI, 32'h0000_0000);
    rd_chk(TBC_IDX_IRQ_STAT, 32'h0000_0000);
    rd_chk(TBC_IDX_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, TBC_IDX_RATIO, 32'hFFFF_FFFF);
    rd_chk(TBC_IDX_RATIO, 32'h0000_000F);
    apb(1'b1, TBC_IDX_TRIM_HI, 32'hFFFF_FFFF);
    rd_chk(TBC_IDX_TRIM_HI, 32'h0000_0007);
    apb(1'b1, TBC_IDX_TRIM_LO, 32'h0000_01FF);
    rd_chk(TBC_IDX_TRIM_LO, 32'h0000_00FF);
    // largest positive trim for the chain run below
    apb(1'b1, TBC_IDX_TRIM_HI, 32'h0000_0003);
    apb(1'b1, TBC_IDX_TRIM_LO, 32'h0000_00FF);
    // unmapped place: refused with an error and zero data
    apb(1'b1, 16'hF010, 32'h0000_00FF);
    chk_bit(re, 1'b1);
    apb(1'b0, 16'hF010, 32'h0000_0000);
    chk_bit(re, 1'b1);
    chk_val(rq, 32'h0000_0000);
    // divider ratios: gap in fast edges between strobes is sixteen minus the field
    foreach (ks[i])
    begin
      apb(1'b1, TBC_IDX_RATIO, {28'h0, ks[i]});
      repeat (700) @(posedge sys_clk);
      chk_val(strobe_gap, 32'h10 - ks[i]);
    end
    // fast period is eight cycles: 128 cycles advance the prescaler by 16, 256 by 32
    rq = {26'h0, fast_taps};
    repeat (128) @(posedge sys_clk);
    chk_val({26'h0, fast_taps}, rq ^ 32'h0000_0020);
    repeat (128) @(posedge sys_clk);
    chk_val({26'h0, fast_taps}, rq);
    // chain: 0x2680 falls plus two trim inserts; 128, 32, 16 and 2 Hz taps end high
    u_far.run_slow(9856);
    rd_stable(32'h0000_004D);
    chk_val({24'h0, slow_taps[15:8]}, 32'h0000_004D);
    chk_val({17'h0, slow_taps[15:1]}, 32'h0000_2684);
    chk_bit(freq_measure_gate, 1'b0);
    rd_chk(TBC_IDX_IRQ_STAT, 32'h0000_0007);
    chk_bit(irq, 1'b0);
    apb(1'b1, TBC_IDX_IRQ_MASK, 32'h0000_000F);
    @(negedge sys_clk);
    chk_bit(irq, 1'b1);
    apb(1'b1, TBC_IDX_IRQ_STAT, 32'h0000_000F);
    rd_chk(TBC_IDX_IRQ_STAT, 32'h0000_0000);
    chk_bit(irq, 1'b0);
    // clearing by write makes every high readout tap fall at once, data ignored
    apb(1'b1, TBC_IDX_READOUT, 32'h0000_00FF);
    rd_stable(32'h0000_0000);
    rd_chk(TBC_IDX_IRQ_STAT, 32'h0000_000F);
    chk_bit(irq, 1'b1);
    apb(1'b1, TBC_IDX_IRQ_STAT, 32'h0000_0001);
    rd_chk(TBC_IDX_IRQ_STAT, 32'h0000_000E);
    apb(1'b1, TBC_IDX_IRQ_MASK, 32'h0000_0001);
    @(negedge sys_clk);
    chk_bit(irq, 1'b0);
    // most negative trim: the accumulator wraps once in this run, one count dropped
    apb(1'b1, TBC_IDX_TRIM_HI, 32'h0000_0004);
    apb(1'b1, TBC_IDX_TRIM_LO, 32'h0000_0000);
    u_far.run_slow(2448);
    rd_stable(32'h0000_0013);
    chk_val({17'h0, slow_taps[15:1]}, 32'h0000_0992);
    test_done();
  end
endmodule : tb_top
